// file: gpp_regs.svh
`ifndef GPP_REGS_SVH
`define GPP_REGS_SVH

// ------------------------------------------------------------
// register indexes (byte address = index * 4)
// ------------------------------------------------------------
`define GPP_DR0_IDX   14'h0000
`define GPP_DR1_IDX   14'h0001
`define GPP_DR2_IDX   14'h0002
`define GPP_DR3_IDX   14'h0003
`define GPP_DR4_IDX   14'h0004
`define GPP_RMW_BASE  14'h0010
`define GPP_ODE0_IDX  14'h1f82
`define GPP_ODE3_IDX  14'h1f83
`define GPP_ODE4_IDX  14'h1f84
`define GPP_CR0_IDX   14'h1f86
`define GPP_CR1_IDX   14'h1f87
`define GPP_CR3_IDX   14'h1f89
`define GPP_CR4_IDX   14'h1f8a
`define GPP_NO_IDX    14'h3fff

// ------------------------------------------------------------
// implemented bits and reset values
// ------------------------------------------------------------
`define GPP_MASK0     8'h0f
`define GPP_MASK1     8'hff
`define GPP_MASK2     8'h07
`define GPP_MASK3     8'hff
`define GPP_MASK4     8'hff
`define GPP_DR_RST    8'h00
`define GPP_DR2_RST   8'h07
`define GPP_CR_RST    8'h00
`define GPP_ODE_RST   8'h00

`endif

// file: gpp_pkg.sv
package gpp_pkg;

	localparam int GPP_PORTS = 5;

	typedef logic [GPP_PORTS-1:0][7:0] gpp_bus_t;

	// drive of all port pins, travels together
	typedef struct packed {
		gpp_bus_t out;
		gpp_bus_t oe;
	} gpp_drive_s;

	typedef enum logic [1:0] {
		GPP_VIEW_PIN,
		GPP_VIEW_LATCH,
		GPP_VIEW_REG,
		GPP_VIEW_NONE
	} gpp_view_e;

endpackage : gpp_pkg

// file: gpp_ports.sv
`timescale 1ns/100ps
`default_nettype none
`include "gpp_regs.svh"

// What this block does
// (R1) output values held in latches; pin inputs pass unlatched to reads
// (R2) software keeps inputs stable or reads them several times
// (R3) pin values sampled in the setup cycle of a read
// (R4) output latch written in the access cycle of a write
// (R5) latch view for read-modify-write class, pin view for data register reads
// (R6) first port: four bits, direction resets to input, one selects output
// (R7) first port output latch resets to zero
// (R8) first port open-drain select resets to tri-state, one selects open-drain
// (R9) open-drain ports: read-modify-write reads latch, others read pins
// (R10) second port: eight bits, direction and latch reset to zero
// (R11) third port: three bits, latch resets to ones; keep one for inputs
// (R12) third port read: bits seven to three undefined, read as zero
// (R13) falling edge on a third port pin, driven or external, sets interrupt
// (R14) in stop mode third port bit zero goes high impedance always
// (R15) fourth port: eight bits, direction and latch reset to zero
// (R16) fourth port open-drain select resets to zero, one selects open-drain
// (R17) software sets fourth port latch to one before pwm drives pins
// (R18) software disables emergency stop one before plain use of fourth port
// (R19) fifth port direction register at its index, resets to zero
// (R20) fifth port open-drain select at its index, resets to zero
// (R21) software sets fifth port bit seven to output for timer use
// (R22) software uses no read-modify-write on write-only registers
// (R23) open-drain drives low on zero and releases on one; tri-state drives latch
module gpp_ports (
	input  wire logic            clock,
	input  wire logic            rst_b,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [15:0]     paddr,
	input  wire logic [31:0]     pwdata,
	input  wire logic [3:0]      pstrb,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	input  wire gpp_pkg::gpp_bus_t   pinIn,
	output gpp_pkg::gpp_drive_s      pinDrive,
	input  wire logic            stopMode,
	input  wire logic            stopOutputHoldEnable,
	output logic      [2:0]      extIntSet
);
	import gpp_pkg::*;

	// ------------------------------------------------------------
	// per-port constants
	// ------------------------------------------------------------
	localparam logic [13:0] DR_IDX  [GPP_PORTS] = '{`GPP_DR0_IDX, `GPP_DR1_IDX, `GPP_DR2_IDX,
		`GPP_DR3_IDX, `GPP_DR4_IDX};
	localparam logic [13:0] CR_IDX  [GPP_PORTS] = '{`GPP_CR0_IDX, `GPP_CR1_IDX, `GPP_NO_IDX,
		`GPP_CR3_IDX, `GPP_CR4_IDX};
	localparam logic [13:0] ODE_IDX [GPP_PORTS] = '{`GPP_ODE0_IDX, `GPP_NO_IDX, `GPP_NO_IDX,
		`GPP_ODE3_IDX, `GPP_ODE4_IDX};
	localparam logic [7:0]  MASK    [GPP_PORTS] = '{`GPP_MASK0, `GPP_MASK1, `GPP_MASK2,
		`GPP_MASK3, `GPP_MASK4};
	localparam logic [7:0]  DR_RST  [GPP_PORTS] = '{`GPP_DR_RST, `GPP_DR_RST, `GPP_DR2_RST,
		`GPP_DR_RST, `GPP_DR_RST};

	gpp_bus_t    latch;
	gpp_bus_t    dir;
	gpp_bus_t    openDrain;
	gpp_bus_t    pinMeta;
	gpp_bus_t    pinSync;
	logic [2:0]  thirdPrev;
	logic [13:0] index;
	logic        setupPhase;
	logic        writeTake;
	logic [31:0] readValue;
	logic        readMapped;
	gpp_drive_s  next_drive;

	assign index      = paddr[15:2];
	assign setupPhase = psel & ~penable;
	assign writeTake  = psel & penable & pwrite & pready & pstrb[0];

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pinMeta <= '0;
			pinSync <= '0;
		end else begin
			pinMeta <= pinIn;
			pinSync <= pinMeta;
		end
	end

	// ------------------------------------------------------------
	// output latches, direction and open-drain registers
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			for (int p = 0; p < GPP_PORTS; p++) begin
				latch[p] <= DR_RST[p]; // R7 R10 R11 R15
			end
		end else if (writeTake) begin
			for (int p = 0; p < GPP_PORTS; p++) begin
				if (index == DR_IDX[p] || index == `GPP_RMW_BASE + 14'(p)) begin
					latch[p] <= pwdata[7:0] & MASK[p]; // R1 R4
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			for (int p = 0; p < GPP_PORTS; p++) begin
				dir[p] <= `GPP_CR_RST; // R6 R10 R15 R19
			end
		end else if (writeTake) begin
			for (int p = 0; p < GPP_PORTS; p++) begin
				if (CR_IDX[p] != `GPP_NO_IDX && index == CR_IDX[p]) begin
					dir[p] <= pwdata[7:0] & MASK[p]; // R6 R19
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			for (int p = 0; p < GPP_PORTS; p++) begin
				openDrain[p] <= `GPP_ODE_RST; // R8 R16 R20
			end
		end else if (writeTake) begin
			for (int p = 0; p < GPP_PORTS; p++) begin
				if (ODE_IDX[p] != `GPP_NO_IDX && index == ODE_IDX[p]) begin
					openDrain[p] <= pwdata[7:0] & MASK[p]; // R8 R16 R20
				end
			end
		end
	end

	// ------------------------------------------------------------
	// read view selection
	// ------------------------------------------------------------
	always_comb begin
		readValue  = '0;
		readMapped = 1'b0;
		for (int p = 0; p < GPP_PORTS; p++) begin
			if (index == DR_IDX[p]) begin
				readValue  = {24'h000000, pinSync[p] & MASK[p]}; // R3 R5 R9 R12
				readMapped = 1'b1;
			end
			if (index == `GPP_RMW_BASE + 14'(p)) begin
				readValue  = {24'h000000, latch[p]}; // R5 R9
				readMapped = 1'b1;
			end
			if (CR_IDX[p] != `GPP_NO_IDX && index == CR_IDX[p]) begin
				readValue  = {24'h000000, dir[p]};
				readMapped = 1'b1;
			end
			if (ODE_IDX[p] != `GPP_NO_IDX && index == ODE_IDX[p]) begin
				readValue  = {24'h000000, openDrain[p]};
				readMapped = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// apb answer: data sampled in setup, given in access
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pready <= 1'b0;
		end else begin
			pready <= setupPhase;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end else if (setupPhase) begin
			prdata  <= pwrite ? 32'h00000000 : readValue; // R3
			pslverr <= ~readMapped;
		end
	end

	// ------------------------------------------------------------
	// pin drive
	// ------------------------------------------------------------
	always_comb begin
		next_drive = '0;
		for (int p = 0; p < GPP_PORTS; p++) begin
			for (int b = 0; b < 8; b++) begin
				if (MASK[p][b]) begin
					if (p == 2) begin
						next_drive.oe[p][b] = ~latch[p][b]; // R11 R23
					end else if (openDrain[p][b]) begin
						next_drive.oe[p][b] = dir[p][b] & ~latch[p][b]; // R23
					end else begin
						next_drive.oe[p][b]  = dir[p][b]; // R23
						next_drive.out[p][b] = latch[p][b];
					end
					if (stopMode && ((p == 2 && b == 0) || !stopOutputHoldEnable)) begin
						next_drive.oe[p][b] = 1'b0; // R14
					end
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pinDrive <= '0;
		end else begin
			pinDrive <= next_drive;
		end
	end

	// ------------------------------------------------------------
	// third port falling edge to interrupt latch
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			// starts low so the synchronisers filling after reset give no false edge
			thirdPrev <= 3'h0;
			extIntSet <= 3'h0;
		end else begin
			thirdPrev <= pinSync[2][2:0];
			extIntSet <= thirdPrev & ~pinSync[2][2:0]; // R13
		end
	end

endmodule : gpp_ports
`default_nettype wire

// file: gpp_ports_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "gpp_regs.svh"
module gpp_ports_props import gpp_pkg::*; (
	input wire logic             clock,
	input wire logic             rst_b,
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pwrite,
	input wire logic [15:0]      paddr,
	input wire logic [31:0]      pwdata,
	input wire logic [3:0]       pstrb,
	input wire logic [31:0]      prdata,
	input wire logic             pready,
	input wire logic             pslverr,
	input wire gpp_pkg::gpp_bus_t   pinIn,
	input wire gpp_pkg::gpp_drive_s pinDrive,
	input wire logic             stopMode,
	input wire logic             stopOutputHoldEnable,
	input wire logic [2:0]       extIntSet
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
	a_ready_single: assert property (pready |=> !pready) else $error("ready held too long");
	a_third_upper_zero: assert property (pready && paddr[15:2] == `GPP_DR2_IDX |-> prdata[31:3] == 29'h0)
		else $error("third port upper bits set");
	a_stop_bit_zero: assert property ($past(stopMode) |-> !pinDrive.oe[2][0]) else $error("bit zero driven in stop");
	a_stop_all_off: assert property ($past(stopMode && !stopOutputHoldEnable) |-> pinDrive.oe == '0)
		else $error("outputs driven in stop");
	a_third_open_drain: assert property (pinDrive.out[2] == 8'h00) else $error("third port drives high");
	a_unused_quiet: assert property (pinDrive.oe[0][7:4] == 4'h0 && pinDrive.oe[2][7:3] == 5'h0)
		else $error("unimplemented bit driven");
	a_int_on_fall: assert property ($fell(pinIn[2][0]) |-> ##[2:4] extIntSet[0]) else $error("no interrupt on fall");
	a_int_single: assert property (extIntSet[0] |=> !extIntSet[0]) else $error("interrupt pulse too long");
	cover property (pready && pslverr);
	cover property (extIntSet[0]);
	cover property (stopMode && pinDrive.oe[4] != 8'h00);
endmodule : gpp_ports_props
`default_nettype wire

// file: gpp_board.sv
`timescale 1ns/100ps
`default_nettype none
module gpp_board import gpp_pkg::*; (
	input wire gpp_pkg::gpp_drive_s pinDrive,
	input wire gpp_pkg::gpp_bus_t   extOe,
	input wire gpp_pkg::gpp_bus_t   extVal,
	output gpp_pkg::gpp_bus_t       pinIn
);
	// pull-up on every line; the bench holds its levels steady between reads
	assign pinIn = (pinDrive.oe & pinDrive.out) | (~pinDrive.oe & ((extOe & extVal) | ~extOe));
endmodule : gpp_board
`default_nettype wire

// file: testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "gpp_regs.svh"
`define CHK(s,x,g) begin checks++; if ((g) !== (x)) begin error_cnt++; $display("Error %s exp %h got %h", s, x, g); end end
module testbench;
	import gpp_pkg::*;
	logic clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
	logic stopMode = 0, stopOutputHoldEnable = 1, pready, pslverr, e;
	logic [15:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic [3:0] pstrb = 4'hf;
	logic [2:0] extIntSet;
	gpp_bus_t pinIn, extOe = '0, extVal = '0;
	gpp_drive_s pinDrive;
	int error_cnt = 0, checks = 0, cyc = 0, n;
	logic [13:0] rstIdx [11] = '{`GPP_CR0_IDX, `GPP_ODE0_IDX, `GPP_RMW_BASE, `GPP_CR1_IDX, `GPP_RMW_BASE + 14'h1,
		`GPP_CR3_IDX, `GPP_ODE3_IDX, `GPP_RMW_BASE + 14'h3, `GPP_CR4_IDX, `GPP_ODE4_IDX, `GPP_RMW_BASE + 14'h4};
	always #10 clock = ~clock;
	gpp_ports DUT (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pinIn(pinIn),
		.pinDrive(pinDrive), .stopMode(stopMode), .stopOutputHoldEnable(stopOutputHoldEnable), .extIntSet(extIntSet));
	gpp_board board (.pinDrive(pinDrive), .extOe(extOe), .extVal(extVal), .pinIn(pinIn));
	task print_verdict;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : print_verdict
	task apb(input logic w, input logic [13:0] i, input logic [7:0] d);
		int k;
		@(posedge clock);
		psel <= 1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge clock);
		penable <= 1;
		k = 0;
		do begin @(posedge clock); k++; end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task rdchk(input logic [13:0] i, input logic [31:0] x);
		apb(1'b0, i, 8'h0);
		`CHK("prdata", x, r)
		`CHK("pslverr", 1'b0, e)
	endtask : rdchk
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin error_cnt++; print_verdict; end
	end
	initial begin
		repeat (6) @(posedge clock);
		rst_b <= 1;
		foreach (rstIdx[j]) rdchk(rstIdx[j], 32'h0);
		rdchk(`GPP_RMW_BASE + 14'h2, 32'h7);
		rdchk(`GPP_DR2_IDX, 32'h7);
		apb(1'b1, `GPP_RMW_BASE + 14'h1, 8'h3c);
		extOe[1] <= 8'hff;
		extVal[1] <= 8'h81;
		repeat (3) @(posedge clock);
		rdchk(`GPP_DR1_IDX, 32'h81);
		rdchk(`GPP_RMW_BASE + 14'h1, 32'h3c);
		apb(1'b1, `GPP_DR0_IDX, 8'hff);
		rdchk(`GPP_RMW_BASE, 32'hf);
		apb(1'b1, `GPP_RMW_BASE + 14'h4, 8'ha5);
		apb(1'b1, `GPP_CR4_IDX, 8'hff);
		repeat (3) @(posedge clock);
		#1 `CHK("out4", 8'ha5, pinDrive.out[4])
		`CHK("oe4", 8'hff, pinDrive.oe[4])
		rdchk(`GPP_DR4_IDX, 32'ha5);
		apb(1'b1, `GPP_ODE4_IDX, 8'h0f);
		extOe[4] <= 8'h01;
		repeat (3) @(posedge clock);
		#1 `CHK("oe4", 8'hfa, pinDrive.oe[4])
		`CHK("out4", 8'ha0, pinDrive.out[4])
		rdchk(`GPP_DR4_IDX, 32'ha4);
		rdchk(`GPP_RMW_BASE + 14'h4, 32'ha5);
		pstrb <= 4'h0;
		apb(1'b1, `GPP_RMW_BASE + 14'h4, 8'h00);
		pstrb <= 4'hf;
		rdchk(`GPP_RMW_BASE + 14'h4, 32'ha5);
		apb(1'b1, `GPP_DR3_IDX, 8'hff);
		rdchk(`GPP_RMW_BASE + 14'h3, 32'hff);
		apb(1'b1, `GPP_RMW_BASE + 14'h2, 8'h06);
		n = 0;
		repeat (8) begin @(posedge clock); if (extIntSet[0] === 1'b1) n++; end
		`CHK("pulses", 1, n)
		stopMode <= 1;
		repeat (2) @(posedge clock);
		#1 `CHK("oe20", 1'b0, pinDrive.oe[2][0])
		`CHK("oe4", 8'hfa, pinDrive.oe[4])
		@(posedge clock) stopOutputHoldEnable <= 0;
		repeat (2) @(posedge clock);
		#1 `CHK("oe4", 8'h00, pinDrive.oe[4])
		@(posedge clock) stopMode <= 0;
		stopOutputHoldEnable <= 1;
		apb(1'b0, `GPP_NO_IDX, 8'h0);
		`CHK("pslverr", 1'b1, e)
		print_verdict;
	end
endmodule : testbench
bind gpp_ports gpp_ports_props chk (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pinIn(pinIn),
	.pinDrive(pinDrive), .stopMode(stopMode), .stopOutputHoldEnable(stopOutputHoldEnable), .extIntSet(extIntSet));
`default_nettype wire
